/* asuc_pkg.sv */
package asuc_pkg;
  // register byte offsets
  localparam logic [7:0] ASUC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ASUC_OFF_SELA   = 8'h04;
  localparam logic [7:0] ASUC_OFF_SELB   = 8'h08;
  localparam logic [7:0] ASUC_OFF_RESULT = 8'h0C;
  localparam logic [7:0] ASUC_OFF_LIVE   = 8'h10;
  localparam logic [7:0] ASUC_OFF_STATUS = 8'h14;
  localparam logic [7:0] ASUC_OFF_MASK   = 8'h18;
  localparam logic [7:0] ASUC_OFF_SLEEP  = 8'h1C;
  // control register bits
  localparam int ASUC_CTRL_EN    = 0;
  localparam int ASUC_CTRL_START = 1;
  localparam int ASUC_CTRL_AUTO  = 2;
  localparam int ASUC_CTRL_FREE  = 3;
  localparam int ASUC_CTRL_IE    = 4;
  localparam int ASUC_CTRL_PS_LO = 8;
  localparam int ASUC_PS_W       = 3;
  // select fields
  localparam int ASUC_MUX_W  = 6;
  localparam int ASUC_GAIN_W = 2;
  localparam int ASUC_REF_W  = 3;
  localparam int ASUC_GAIN_LO = 8;
  // status bits
  localparam int ASUC_ST_DONE = 0;
  localparam int ASUC_ST_TRIG = 1;
  localparam int ASUC_ST_W    = 2;
  // sleep register codes
  localparam logic [1:0] ASUC_SLP_RUN   = 2'h0;
  localparam logic [1:0] ASUC_SLP_IDLE  = 2'h1;
  localparam logic [1:0] ASUC_SLP_NOISE = 2'h2;
  localparam logic [1:0] ASUC_SLP_DEEP  = 2'h3;
  // reference choices
  localparam logic [2:0] ASUC_REF_VCC   = 3'h0;
  localparam logic [2:0] ASUC_REF_EXT   = 3'h1;
  localparam logic [2:0] ASUC_REF_I1V1  = 3'h2;
  localparam logic [2:0] ASUC_REF_I2V2  = 3'h3;
  localparam logic [2:0] ASUC_REF_I4V0  = 3'h4;
  // conversion timing in converter clocks
  localparam int ASUC_CONV_CYC  = 15;
  localparam int ASUC_FIRST_CYC = 26;
  localparam int ASUC_RES_W     = 10;
  localparam logic [9:0] ASUC_RES_MAX = 10'h3FF;
  localparam logic [1:0] ASUC_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    ASUC_IDLE = 2'b00,
    ASUC_CONV = 2'b01,
    ASUC_DONE = 2'b10
  } asuc_state_type;
endpackage

/* asuc_prescaler.sv */
`timescale 1ns/10ps
module asuc_prescaler import asuc_pkg::*; #(
  parameter int PS_W = ASUC_PS_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic restart,
  input wire logic [PS_W-1:0] div_sel,
  output logic tick
);
  logic [7:0] cnt_q;
  logic [7:0] top;
  // divide by 2^(div_sel+1)
  assign top = 8'((1 << (div_sel + 1)) - 1);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (!enable || restart) begin
      // held in reset while the converter is off
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == top);
      cnt_q <= (cnt_q == top) ? '0 : cnt_q + 8'h01;
    end
  end
endmodule // asuc_prescaler

/* asuc_control.sv */
`timescale 1ns/10ps
// How it works
// - buffered selects copied live while enabled and idle
// - live channel and reference frozen during conversion
// - start taken at next converter clock edge
// - safe writes apply from next conversion
// - free running keeps old channel once
// - reference: supply, external, internal 1.1/2.2/4V
// - idle/noise sleep entry with IE set and auto trigger off auto-starts a conversion, single unless free running
// - completion interrupt raised even if woken earlier
// - deep sleep leaves converter enabled
// - results are 10-bit unsigned, clamped 0x3FF
// - completion writes result, done, clears start unless free running
// - trigger rising edge restarts prescaler, starts
module asuc_control import asuc_pkg::*; #(
  parameter int MUX_W = ASUC_MUX_W,
  parameter int RES_W = ASUC_RES_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic trigger_in,
  input wire logic [RES_W:0] analog_sample,
  output logic [MUX_W-1:0] live_input_select,
  output logic [ASUC_GAIN_W-1:0] live_gain_select,
  output logic [ASUC_REF_W-1:0] live_reference_select,
  output logic sample_hold,
  output logic irq
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic conv_en_q, start_q, auto_q, free_q, ie_q;
  logic [ASUC_PS_W-1:0] ps_q;
  logic [MUX_W-1:0] input_select_bits_q;
  logic [ASUC_GAIN_W-1:0] gain_select_bits_q;
  logic [ASUC_REF_W-1:0] reference_select_bits_q;
  logic [RES_W-1:0] result_q;
  logic [ASUC_ST_W-1:0] status_q, mask_q;
  logic [1:0] sleep_q;
  logic first_q;
  logic [4:0] cyc_q;
  logic trig_m_q, trig_s_q, trig_p_q;
  logic [RES_W:0] samp_m_q, samp_s_q;
  asuc_state_type state_q;
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic tick;
  logic trig_rise, start_req, sleep_start, done_ev, busy;
  logic bus_wr, live_copy;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      addr_q <= '0;
    end else if (hready) begin
      wr_pend_q <= hsel && hwrite && (htrans == ASUC_HTRANS_NONSEQ);
      addr_q <= haddr[7:0];
    end
  end
  assign bus_wr = wr_pend_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data registered in the address phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (hready && hsel && !hwrite && htrans == ASUC_HTRANS_NONSEQ) begin
      unique case (haddr[7:0])
        ASUC_OFF_CTRL: hrdata <= {21'h0, ps_q, 3'h0, ie_q, free_q, auto_q,
                                  start_q, conv_en_q};
        ASUC_OFF_SELA: hrdata <= {{(32-MUX_W){1'b0}}, input_select_bits_q};
        ASUC_OFF_SELB: hrdata <= {22'h0, gain_select_bits_q, 5'h0,
                                  reference_select_bits_q};
        ASUC_OFF_RESULT: hrdata <= {{(32-RES_W){1'b0}}, result_q};
        ASUC_OFF_LIVE: hrdata <= {13'h0, live_reference_select, 6'h0,
                                  live_gain_select, {(8-MUX_W){1'b0}},
                                  live_input_select};
        ASUC_OFF_STATUS: hrdata <= {30'h0, status_q};
        ASUC_OFF_MASK: hrdata <= {30'h0, mask_q};
        ASUC_OFF_SLEEP: hrdata <= {30'h0, sleep_q};
        default: hrdata <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // software-written buffers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      input_select_bits_q <= '0;
      gain_select_bits_q <= '0;
      reference_select_bits_q <= ASUC_REF_VCC;
      mask_q <= '0;
      sleep_q <= ASUC_SLP_RUN;
    end else if (bus_wr) begin
      if (hit(addr_q, ASUC_OFF_SELA))
        input_select_bits_q <= hwdata[MUX_W-1:0];
      if (hit(addr_q, ASUC_OFF_SELB)) begin
        gain_select_bits_q <= hwdata[ASUC_GAIN_LO +: ASUC_GAIN_W];
        // reference choices, others fall back to supply
        if (hwdata[ASUC_REF_W-1:0] <= ASUC_REF_I4V0)
          reference_select_bits_q <= hwdata[ASUC_REF_W-1:0];
        else
          reference_select_bits_q <= ASUC_REF_VCC;
      end
      if (hit(addr_q, ASUC_OFF_MASK)) mask_q <= hwdata[ASUC_ST_W-1:0];
      if (hit(addr_q, ASUC_OFF_SLEEP)) sleep_q <= hwdata[1:0];
    end else if (done_ev && sleep_q != ASUC_SLP_DEEP) begin
      sleep_q <= ASUC_SLP_RUN;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  assign busy = (state_q == ASUC_CONV);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_en_q <= 1'b0;
      start_q <= 1'b0;
      auto_q <= 1'b0;
      free_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= '0;
    end else begin
      if (bus_wr && hit(addr_q, ASUC_OFF_CTRL)) begin
        conv_en_q <= hwdata[ASUC_CTRL_EN];
        auto_q <= hwdata[ASUC_CTRL_AUTO];
        free_q <= hwdata[ASUC_CTRL_FREE];
        ie_q <= hwdata[ASUC_CTRL_IE];
        ps_q <= hwdata[ASUC_CTRL_PS_LO +: ASUC_PS_W];
        // writing zero cannot abort a running conversion
        if (hwdata[ASUC_CTRL_START] && hwdata[ASUC_CTRL_EN])
          start_q <= 1'b1;
        if (!hwdata[ASUC_CTRL_EN])
          start_q <= 1'b0;
      end else if (sleep_start || (trig_rise && conv_en_q)) begin
        start_q <= 1'b1;
      end else if (done_ev && !free_q) begin
        start_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // trigger and sample synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_m_q <= 1'b0;
      trig_s_q <= 1'b0;
      trig_p_q <= 1'b0;
      samp_m_q <= '0;
      samp_s_q <= '0;
    end else begin
      trig_m_q <= trigger_in;
      trig_s_q <= trig_m_q;
      trig_p_q <= trig_s_q;
      samp_m_q <= analog_sample;
      samp_s_q <= samp_m_q;
    end
  end
  assign trig_rise = auto_q && trig_s_q && !trig_p_q && !busy;
  assign sleep_start = conv_en_q && !busy && !start_q && !auto_q
                       && ie_q && (sleep_q == ASUC_SLP_IDLE ||
                                   sleep_q == ASUC_SLP_NOISE);
  assign start_req = start_q && conv_en_q;

  asuc_prescaler #(.PS_W(ASUC_PS_W)) u_ps (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(conv_en_q),
    .restart(trig_rise && conv_en_q),
    .div_sel(ps_q),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ASUC_IDLE;
      cyc_q <= '0;
      first_q <= 1'b1;
      result_q <= '0;
      sample_hold <= 1'b0;
    end else if (!conv_en_q) begin
      state_q <= ASUC_IDLE;
      cyc_q <= '0;
      first_q <= 1'b1;
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= 1'b0;
      unique case (state_q)
        ASUC_IDLE, ASUC_DONE: begin
          state_q <= ASUC_IDLE;
          if (start_req && tick) begin
            state_q <= ASUC_CONV;
            cyc_q <= '0;
          end
        end
        ASUC_CONV: begin
          if (tick) begin
            cyc_q <= cyc_q + 5'h01;
            if (cyc_q == 5'(first_q ? ASUC_FIRST_CYC - 1
                                     : ASUC_CONV_CYC - 1)) begin
              // free running starts the next one at once
              state_q <= (free_q && start_q) ? ASUC_CONV : ASUC_DONE;
              cyc_q <= '0;
              first_q <= 1'b0;
              // 10-bit unsigned, clamp at full scale
              result_q <= samp_s_q[RES_W] ? ASUC_RES_MAX
                                          : samp_s_q[RES_W-1:0];
              sample_hold <= 1'b0;
            end
          end
        end
        default: state_q <= ASUC_IDLE;
      endcase
    end
  end
  assign done_ev = busy && tick && (cyc_q == 5'(first_q ?
                   ASUC_FIRST_CYC - 1 : ASUC_CONV_CYC - 1));

  // ------------------------------------------------------------
  // live selection
  // ------------------------------------------------------------
  // completion copies the buffer even when free running restarts at once,
  // so a later write cannot reach the conversion already under way
  assign live_copy = done_ev || !(busy || (start_req && tick));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_input_select <= '0;
      live_gain_select <= '0;
      live_reference_select <= ASUC_REF_VCC;
    end else if (conv_en_q && live_copy) begin
      // safe writes land in next conversion
      // free run restart keeps held channel once
      live_input_select <= input_select_bits_q;
      live_gain_select <= gain_select_bits_q;
      live_reference_select <= reference_select_bits_q;
    end
  end

  // ------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= '0;
      irq <= 1'b0;
    end else begin
      // set wins over write-one-to-clear
      for (int i = 0; i < ASUC_ST_W; i++) begin
        if ((i == ASUC_ST_DONE && done_ev) ||
            (i == ASUC_ST_TRIG && trig_rise))
          status_q[i] <= 1'b1;
        else if (bus_wr && hit(addr_q, ASUC_OFF_STATUS) && hwdata[i])
          status_q[i] <= 1'b0;
      end
      irq <= |(status_q & mask_q);
    end
  end
endmodule // asuc_control

/* asuc_properties.sv */
`timescale 1ns/10ps
// ----------------------------------------
// port checks
// ----------------------------------------
module asuc_properties import asuc_pkg::*; #(
  parameter int MUX_W = ASUC_MUX_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [MUX_W-1:0] live_input_select,
  input wire logic [ASUC_REF_W-1:0] live_reference_select,
  input wire logic sample_hold,
  input wire logic irq
);
  logic ap;
  logic rd_res_q;
  logic rd_bad_q;
  logic wr_mask_q;
  logic [ASUC_ST_W-1:0] mask_sh_q;
  assign ap = hsel && hready && htrans == ASUC_HTRANS_NONSEQ;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_res_q <= 1'b0;
      rd_bad_q <= 1'b0;
      wr_mask_q <= 1'b0;
    end else begin
      rd_res_q <= ap && !hwrite && haddr[7:0] == ASUC_OFF_RESULT;
      rd_bad_q <= ap && !hwrite && haddr[7:0] > ASUC_OFF_SLEEP;
      wr_mask_q <= ap && hwrite && haddr[7:0] == ASUC_OFF_MASK;
    end
  end
  // shadow of the mask, written in the data phase like the design's
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_sh_q <= '0;
    end else if (wr_mask_q) begin
      mask_sh_q <= hwdata[ASUC_ST_W-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ready_always: assert property (hreadyout)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_hold_unused: assert property (!sample_hold)
    else $error("sample_hold raised");
  a_ref_legal: assert property (
    live_reference_select <= ASUC_REF_I4V0) else $error("bad reference");
  a_result_width: assert property (
    rd_res_q |-> hrdata[31:10] == 22'h000000) else $error("result too wide");
  a_unmapped_zero: assert property (rd_bad_q |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (
    (mask_sh_q == '0) [*2] |-> !irq) else $error("irq while masked");
  a_irq_unmask: assert property (
    wr_mask_q && hwdata[1:0] == 2'h0 |-> ##2 !irq) else $error("irq stuck");
  a_reset_clean: assert property (
    $fell(sys_rst) |-> live_input_select == '0 && !irq)
    else $error("outputs not reset");
endmodule // asuc_properties

bind asuc_control asuc_properties #(.MUX_W(MUX_W)) u_props (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .live_input_select(live_input_select),
  .live_reference_select(live_reference_select),
  .sample_hold(sample_hold), .irq(irq));

/* test_adc_select_update_control.sv */
`timescale 1ns/10ps
// ----------------------------------------
// bench
// ----------------------------------------
module test_adc_select_update_control import asuc_pkg::*; ();
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, trigger_in;
  logic sample_hold, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, live_gain_select;
  logic [2:0] hsize, live_reference_select;
  logic [10:0] analog_sample;
  logic [5:0] live_input_select;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [5:0] mux;
    logic [1:0] gain;
    logic [2:0] ref_sel;
  } asuc_row_type;
  // codes 5 to 7 are not references and fall back to the supply
  asuc_row_type rows [0:8] = '{
    '{8'h04, 32'h15, 6'h15, 2'h0, 3'h0}, '{8'h08, 32'h100, 6'h15, 2'h1, 3'h0},
    '{8'h08, 32'h201, 6'h15, 2'h2, 3'h1}, '{8'h08, 32'h302, 6'h15, 2'h3, 3'h2},
    '{8'h08, 32'h003, 6'h15, 2'h0, 3'h3}, '{8'h08, 32'h004, 6'h15, 2'h0, 3'h4},
    '{8'h08, 32'h007, 6'h15, 2'h0, 3'h0}, '{8'h20, 32'hFFFF, 6'h15, 2'h0, 3'h0},
    '{8'h04, 32'h3F, 6'h3F, 2'h0, 3'h0}};
  assign hready = hreadyout;
  asuc_control dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .trigger_in(trigger_in), .analog_sample(analog_sample),
    .live_input_select(live_input_select), .live_gain_select(live_gain_select),
    .live_reference_select(live_reference_select),
    .sample_hold(sample_hold), .irq(irq));
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= ASUC_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      bus(1'b0, ASUC_OFF_STATUS, 32'h0);
      k++;
    end while (rd[ASUC_ST_DONE] !== 1'b1 && k < 200);
    chk("done flag", 1, rd[ASUC_ST_DONE]);
  endtask
  task automatic conv(input logic [31:0] ctrl, input logic [5:0] nmux,
      input logic [10:0] s, input logic [9:0] exp);
    logic [5:0] old_mux;
    old_mux = live_input_select;
    analog_sample <= s;
    bus(1'b1, ASUC_OFF_CTRL, ctrl);
    if (ctrl[ASUC_CTRL_AUTO]) trigger_in <= 1'b1;
    else if (!ctrl[ASUC_CTRL_START]) bus(1'b1, ASUC_OFF_SLEEP, 32'h2);
    // a converter clock or more after the start, so the write is safe
    repeat (8) @(posedge clk);
    bus(1'b1, ASUC_OFF_SELA, {26'h0, nmux});
    repeat (3) @(posedge clk);
    chk("frozen input", old_mux, live_input_select);
    wait_done();
    repeat (3) @(posedge clk);
    chk("irq", 1, irq);
    chk("live input", nmux, live_input_select);
    bus(1'b0, ASUC_OFF_RESULT, 32'h0);
    chk("result", exp, rd);
    bus(1'b0, ASUC_OFF_CTRL, 32'h0);
    chk("start bit", 0, rd[ASUC_CTRL_START]);
    bus(1'b0, ASUC_OFF_SLEEP, 32'h0);
    chk("sleep", 0, rd);
    bus(1'b1, ASUC_OFF_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk("irq masked", 0, irq);
    bus(1'b1, ASUC_OFF_MASK, 32'h1);
    trigger_in <= 1'b0;
    bus(1'b1, ASUC_OFF_STATUS, 32'h3);
    repeat (3) @(posedge clk);
    chk("irq cleared", 0, irq);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // runaway guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trigger_in = 1'b0;
    analog_sample = 11'h000;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // selections reach the converter only while it is enabled
    bus(1'b1, ASUC_OFF_CTRL, 32'h1);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].data);
      repeat (3) @(posedge clk);
      chk("live input", rows[i].mux, live_input_select);
      chk("live gain", rows[i].gain, live_gain_select);
      chk("live reference", rows[i].ref_sel, live_reference_select);
    end
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 0, rd);
    bus(1'b0, ASUC_OFF_LIVE, 32'h0);
    chk("live register", 32'h3F, rd);
    bus(1'b1, ASUC_OFF_MASK, 32'h1);
    conv(32'h03, 6'h09, 11'h123, 10'h123);
    conv(32'h05, 6'h0A, 11'h2AB, 10'h2AB);
    conv(32'h11, 6'h0C, 11'h5A5, ASUC_RES_MAX);
    // deep sleep neither starts a conversion nor turns the converter off
    bus(1'b1, ASUC_OFF_SLEEP, 32'h3);
    repeat (60) @(posedge clk);
    bus(1'b0, ASUC_OFF_STATUS, 32'h0);
    chk("deep sleep done", 0, rd[ASUC_ST_DONE]);
    bus(1'b0, ASUC_OFF_CTRL, 32'h0);
    chk("deep sleep enable", 1, rd[ASUC_CTRL_EN]);
    bus(1'b1, ASUC_OFF_SLEEP, 32'h0);
    // free running: a write after completion misses the running conversion
    bus(1'b1, ASUC_OFF_SELA, 32'h05);
    bus(1'b1, ASUC_OFF_CTRL, 32'h0B);
    wait_done();
    bus(1'b1, ASUC_OFF_SELA, 32'h06);
    repeat (3) @(posedge clk);
    chk("free old input", 32'h05, live_input_select);
    bus(1'b1, ASUC_OFF_STATUS, 32'h3);
    wait_done();
    repeat (3) @(posedge clk);
    chk("free new input", 32'h06, live_input_select);
    bus(1'b0, ASUC_OFF_CTRL, 32'h0);
    chk("free start bit", 1, rd[ASUC_CTRL_START]);
    bus(1'b1, ASUC_OFF_CTRL, 32'h0);
    bus(1'b1, ASUC_OFF_STATUS, 32'h3);
    sys_rst <= 1'b1;
    @(posedge clk);
    chk("reset ready", 1, hreadyout);
    chk("reset input", 0, live_input_select);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, ASUC_OFF_SELA, 32'h0);
    chk("reset buffer", 0, rd);
    test_done();
  end
endmodule // test_adc_select_update_control
